/* hdl/cid_decoder.sv */
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module cid_decoder
   import cid_pkg::*;
#(
   parameter int PC_W = CID_PC_W
)(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   output logic [PC_W-1:0]       prog_addr,
   output logic                  prog_rd,
   input  wire logic [15:0]      prog_data,
   input  wire logic             cond_true,
   input  wire logic             pc_written,
   input  wire logic [PC_W-1:0]  pc_load_value,
   input  wire logic [4:0]       alu_flags_in,
   input  wire logic [4:0]       alu_flags_we,
   output logic [15:0]           instr_word,
   output logic [15:0]           operand_word,
   output logic                  exec_stb,
   output logic [1:0]            osc_phase,
   output logic                  dest_to_file,
   output logic                  bank_select_en,
   output logic [7:0]            file_addr,
   output logic [7:0]            bit_mask,
   output logic [2:0]            bit_pos,
   output logic [7:0]            lit8,
   output logic [11:0]           lit12,
   output logic [19:0]           lit20,
   output logic [11:0]           move_src,
   output logic [11:0]           move_dst,
   output logic [1:0]            indirect_pointer_sel,
   output logic [1:0]            table_mode,
   output logic                  fast_save,
   output logic                  fast_restore,
   output logic [4:0]            status_flags
);
   typedef enum logic {CID_S_EXEC, CID_S_OPER} cid_state_t;

   cid_state_t        state_reg;
   logic [1:0]        ctrl_reg;
   logic [PC_W-1:0]   pc_reg;
   logic              cur_dbl_reg, cur_jmp_reg, cur_bra_reg, cur_bcc_reg;
   logic              cur_skip_reg, cur_ret_reg;
   logic [1:0]        phase;
   logic              cycle_end;
   logic              take_nop;
   logic [15:0]       fetch_word;
   logic              f_dst, f_acc, f_fast, f_w2, f_dbl, f_jmp, f_bra, f_bcc;
   logic              f_skip, f_ret, f_tbl, ext_raw;
   logic [2:0]        f_pos;
   logic [7:0]        f_mask;
   logic [1:0]        f_fsr, f_tbl_mode;
   logic [PC_W-1:0]   rel_target, abs_target;
   logic              aw_hold, w_hold;
   logic [7:0]        aw_addr_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   logic              do_write;

   cid_phase u_phase (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .run       (ctrl_reg[CID_CTRL_RUN]),
      .phase     (phase),
      .cycle_end (cycle_end)
   );

   cid_fields u_fields (
      .word     (fetch_word),
      .dst_file (f_dst),
      .acc_bank (f_acc),
      .bit_pos  (f_pos),
      .bit_mask (f_mask),
      .fsr_sel  (f_fsr),
      .tbl_mode (f_tbl_mode),
      .fast     (f_fast),
      .is_w2    (f_w2),
      .is_dbl   (f_dbl),
      .is_jmp   (f_jmp),
      .is_bra   (f_bra),
      .is_bcc   (f_bcc),
      .is_skip  (f_skip),
      .is_ret   (f_ret),
      .is_ext   (),
      .is_tbl   (f_tbl)
   );

   // Relative targets count words from the word after the instruction.
   always_comb begin
      if (cur_bra_reg) begin
         rel_target = pc_reg + PC_W'({{9{instr_word[10]}}, instr_word[10:0], 1'b0}); // see RL14
      end else begin
         rel_target = pc_reg + PC_W'({{12{instr_word[7]}}, instr_word[7:0], 1'b0}); // see RL14
      end
   end
   assign abs_target = PC_W'({prog_data[11:0], instr_word[7:0], 1'b0}); // see RL14

   // A prefetched word is dropped on a taken branch, a return, a counter write or a taken skip.
   always_comb begin
      take_nop = 1'b0;
      if (state_reg == CID_S_EXEC) begin
         take_nop = cur_bra_reg || (cur_bcc_reg && cond_true) || cur_ret_reg
                 || pc_written || (cur_skip_reg && cond_true); // see RL8
      end
   end
   // Decoded from the raw word, since the field decoder sees the muxed word.
   assign ext_raw = (prog_data[15:10] == CID_OP_EXT) || (prog_data == CID_OP_CALLW); // see RL18
   assign fetch_word = (take_nop || (ext_raw && !ctrl_reg[CID_CTRL_EXT]))
                       ? CID_NOP_WORD : prog_data;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= CID_S_EXEC;
         pc_reg    <= CID_PC_RST;
      end else if (do_write && aw_addr_reg == CID_REG_PC && !ctrl_reg[CID_CTRL_RUN]) begin
         pc_reg <= PC_W'(w_data_reg);
      end else if (cycle_end) begin
         unique case (state_reg)
            CID_S_EXEC: begin
               if (cur_jmp_reg) begin
                  pc_reg    <= abs_target; // see RL9
                  state_reg <= CID_S_OPER;
               end else if (cur_dbl_reg) begin
                  pc_reg    <= pc_reg + CID_PC_STEP; // see RL20
                  state_reg <= CID_S_OPER;
               end else if (cur_bra_reg || (cur_bcc_reg && cond_true)) begin
                  pc_reg <= rel_target;
               end else if (cur_ret_reg || pc_written) begin
                  pc_reg <= pc_load_value;
               end else begin
                  pc_reg <= pc_reg + CID_PC_STEP; // see RL11
               end
            end
            CID_S_OPER: begin
               pc_reg    <= pc_reg + CID_PC_STEP;
               state_reg <= CID_S_EXEC; // see RL9
            end
         endcase
      end
   end

   // Instruction latch: at every cycle end except the execute-state end of a double-word's first word.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_word   <= CID_NOP_WORD;
         cur_dbl_reg  <= 1'b0;
         cur_jmp_reg  <= 1'b0;
         cur_bra_reg  <= 1'b0;
         cur_bcc_reg  <= 1'b0;
         cur_skip_reg <= 1'b0;
         cur_ret_reg  <= 1'b0;
      end else if (cycle_end && !(state_reg == CID_S_EXEC && cur_dbl_reg)) begin
         instr_word   <= fetch_word; // see RL1
         cur_dbl_reg  <= f_dbl && !f_w2;
         cur_jmp_reg  <= f_jmp;
         cur_bra_reg  <= f_bra;
         cur_bcc_reg  <= f_bcc;
         cur_skip_reg <= f_skip;
         cur_ret_reg  <= f_ret;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dest_to_file         <= 1'b0;
         bank_select_en       <= 1'b0;
         file_addr            <= 8'h00;
         bit_mask             <= 8'h00;
         bit_pos              <= 3'h0;
         lit8                 <= 8'h00;
         lit12                <= 12'h000;
         move_src             <= 12'h000;
         indirect_pointer_sel <= 2'h0;
         table_mode           <= CID_TBL_KEEP;
         fast_save            <= 1'b0;
         fast_restore         <= 1'b0;
      end else if (cycle_end && !(state_reg == CID_S_EXEC && cur_dbl_reg)) begin
         dest_to_file         <= f_dst; // see RL3
         bank_select_en       <= f_acc; // see RL4
         file_addr            <= fetch_word[7:0]; // see RL2
         bit_mask             <= f_mask; // see RL5
         bit_pos              <= f_pos;
         lit8                 <= fetch_word[7:0]; // see RL13
         lit12                <= fetch_word[11:0]; // see RL13
         move_src             <= fetch_word[11:0]; // see RL15
         indirect_pointer_sel <= f_fsr; // see RL16
         table_mode           <= f_tbl ? f_tbl_mode : CID_TBL_KEEP; // see RL12
         fast_save            <= f_jmp && f_fast; // see RL19
         fast_restore         <= f_ret && f_fast; // see RL19
      end
   end

   // The second word of an executing double-word is consumed as operand data, not as an instruction.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         operand_word <= CID_NOP_WORD;
         move_dst     <= 12'h000;
         lit20        <= 20'h00000;
      end else if (cycle_end && state_reg == CID_S_EXEC && cur_dbl_reg) begin
         operand_word <= prog_data; // see RL6
         move_dst     <= prog_data[11:0]; // see RL15
         lit20        <= {prog_data[11:0], instr_word[7:0]}; // see RL13
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_flags <= 5'h00;
      end else if (cycle_end) begin
         status_flags <= (status_flags & ~alu_flags_we) | (alu_flags_in & alu_flags_we); // see RL17
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exec_stb  <= 1'b0;
         osc_phase <= 2'h0;
         prog_addr <= CID_PC_RST;
         prog_rd   <= 1'b0;
      end else begin
         exec_stb  <= cycle_end;
         osc_phase <= phase;
         prog_addr <= pc_reg;
         prog_rd   <= ctrl_reg[CID_CTRL_RUN];
      end
   end

   // Write channel: address and data are held until both have arrived.
   assign do_write = aw_hold && w_hold && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold       <= 1'b0;
         w_hold        <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= CID_RESP_OK;
      end else begin
         s_axi_awready <= !aw_hold && !s_axi_awready;
         s_axi_wready  <= !w_hold && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold     <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold     <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg == CID_REG_CTRL || aw_addr_reg == CID_REG_PC)
                            ? CID_RESP_OK : CID_RESP_ERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= CID_CTRL_RST;
      end else if (do_write && aw_addr_reg == CID_REG_CTRL && w_strb_reg[0]) begin
         ctrl_reg <= w_data_reg[1:0]; // see RL18
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= CID_RESP_OK;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= CID_RESP_OK;
         unique case (s_axi_araddr)
            CID_REG_CTRL: s_axi_rdata <= {30'h0, ctrl_reg};
            CID_REG_STAT: s_axi_rdata <= {27'h0, cur_dbl_reg, state_reg, 1'b0, phase};
            CID_REG_PC:   s_axi_rdata <= 32'(pc_reg);
            CID_REG_WORD: s_axi_rdata <= {16'h0, instr_word};
            CID_REG_OPER: s_axi_rdata <= {16'h0, operand_word};
            CID_REG_FLAG: s_axi_rdata <= {27'h0, status_flags};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= CID_RESP_ERR;
            end
         endcase
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule : cid_decoder
`default_nettype wire

/* hdl/cid_fields.sv */
`timescale 1ns/100ps
`default_nettype none
module cid_fields
   import cid_pkg::*;
(
   input  wire logic [15:0] word,
   output logic             dst_file,
   output logic             acc_bank,
   output logic [2:0]       bit_pos,
   output logic [7:0]       bit_mask,
   output logic [1:0]       fsr_sel,
   output logic [1:0]       tbl_mode,
   output logic             fast,
   output logic             is_w2,
   output logic             is_dbl,
   output logic             is_jmp,
   output logic             is_bra,
   output logic             is_bcc,
   output logic             is_skip,
   output logic             is_ret,
   output logic             is_ext,
   output logic             is_tbl
);
   logic [3:0] top;
   assign top      = word[15:12];
   assign dst_file = word[9];        // see RL3
   assign acc_bank = word[8];        // see RL4
   assign bit_pos  = word[11:9];     // see RL5
   assign fsr_sel  = word[5:4];      // see RL16
   assign tbl_mode = word[1:0];      // see RL12
   assign is_w2    = (top == CID_W2_TAG); // see RL7
   assign is_tbl   = (word[15:2] == CID_OP_TBL);
   assign is_ret   = (word[15:1] == CID_OP_RET) || (word[15:1] == CID_OP_RETFIE);
   assign is_jmp   = (word[15:9] == CID_OP_CALL) || (word[15:8] == CID_OP_GOTO);
   assign is_dbl   = is_jmp || (top == CID_OP_MOVFF) || (word[15:6] == CID_OP_LFSR); // see RL1
   assign fast     = is_ret ? word[0] : ((word[15:9] == CID_OP_CALL) && word[8]); // see RL19
   assign is_bra   = (top == CID_OP_BRANCH);
   assign is_bcc   = (word[15:11] == CID_OP_BCC);
   assign is_ext   = (word[15:10] == CID_OP_EXT) || (word == CID_OP_CALLW); // see RL18
   // Skip forms: compare-skip, inc/dec-skip and bit-test-skip families.
   assign is_skip  = (word[15:10] == 6'h18) || (word[15:9] == 7'h32)
                  || (word[15:10] == 6'h0B) || (word[15:10] == 6'h0F)
                  || (word[15:11] == 5'h09) || (word[15:13] == 3'h5);
   for (genvar i = 0; i < 8; i++) begin : g_mask
      assign bit_mask[i] = (bit_pos == 3'(i)); // see RL5
   end
endmodule : cid_fields
`default_nettype wire

/* hdl/cid_phase.sv */
`timescale 1ns/100ps
`default_nettype none
module cid_phase
   import cid_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       run,
   output logic [1:0]      phase,
   output logic            cycle_end
);
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1; // see RL10
      end
   end
   assign cycle_end = run && (phase == 2'(CID_PHASES - 1)); // see RL10
endmodule : cid_phase
`default_nettype wire

/* hdl/cid_pkg.sv */
// How it works
// RL1: Program words are 16 bits; four instructions take two consecutive words.
// RL2: Each word splits into an opcode part and operand fields.
// RL3: Destination bit 0 writes the working accumulator, 1 the file register.
// RL4: Access bit 0 uses access RAM; 1 lets the bank select register choose.
// RL5: Three-bit position field selects one of bits 0 through 7.
// RL6: Second words carry ones in their four top bits; 32 operand bits total.
// RL7: A second word executed alone behaves as a no-operation.
// RL8: Single-word takes one cycle; skip or program counter change adds a no-op cycle.
// RL9: Every double-word instruction takes two instruction cycles.
// RL10: One instruction cycle is four oscillator periods.
// RL11: A taken skip over a two-word instruction totals three cycles.
// RL12: Table ops carry a mode: unchanged, post-inc, post-dec or pre-inc.
// RL13: Literals decode as 8, 12 or 20 bit constants by format.
// RL14: Branch field is a signed offset for relative, absolute for call and goto.
// RL15: Register moves carry separate 12-bit source and destination addresses.
// RL16: Destination decodes as 8-bit file address or 2-bit pointer designator.
// RL17: Five status flags: carry, half carry, zero, signed wrap, negative.
// RL18: Decode 75 standard instructions plus the 8 extended stack instructions.
// RL19: Fast bit set saves or restores shadow copies; clear leaves them alone.
// RL20: Double-word execution consumes the second word and steps the counter past it.
package cid_pkg;
   localparam int          CID_PHASES    = 4;
   localparam int          CID_PC_W      = 21;
   localparam logic [7:0]  CID_REG_CTRL  = 8'h00;
   localparam logic [7:0]  CID_REG_STAT  = 8'h04;
   localparam logic [7:0]  CID_REG_PC    = 8'h08;
   localparam logic [7:0]  CID_REG_WORD  = 8'h0C;
   localparam logic [7:0]  CID_REG_OPER  = 8'h10;
   localparam logic [7:0]  CID_REG_FLAG  = 8'h14;
   localparam int          CID_CTRL_RUN  = 0;
   localparam int          CID_CTRL_EXT  = 1;
   localparam logic [1:0]  CID_CTRL_RST  = 2'h0;
   localparam logic [20:0] CID_PC_RST    = 21'h000000;
   localparam logic [20:0] CID_PC_STEP   = 21'h000002;
   localparam logic [15:0] CID_NOP_WORD  = 16'h0000;
   localparam logic [3:0]  CID_W2_TAG    = 4'hF;
   localparam logic [3:0]  CID_OP_MOVFF  = 4'hC;
   localparam logic [6:0]  CID_OP_CALL   = 7'h76;
   localparam logic [9:0]  CID_OP_LFSR   = 10'h3B8;
   localparam logic [7:0]  CID_OP_GOTO   = 8'hEF;
   localparam logic [3:0]  CID_OP_BRANCH = 4'hD;
   localparam logic [4:0]  CID_OP_BCC    = 5'h1C;
   localparam logic [13:0] CID_OP_TBL    = 14'h0002;
   localparam logic [14:0] CID_OP_RET    = 15'h0009;
   localparam logic [14:0] CID_OP_RETFIE = 15'h0008;
   localparam logic [5:0]  CID_OP_EXT    = 6'h3A;
   localparam logic [15:0] CID_OP_CALLW  = 16'h0014;
   localparam logic [1:0]  CID_RESP_OK   = 2'h0;
   localparam logic [1:0]  CID_RESP_ERR  = 2'h2;
   typedef enum logic [1:0] {
      CID_TBL_KEEP, CID_TBL_POSTINC, CID_TBL_POSTDEC, CID_TBL_PREINC
   } cid_tbl_t;
endpackage : cid_pkg

/* verif/cid_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module cid_monitor
   import cid_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        prog_rd,
   input wire logic        exec_stb,
   input wire logic [15:0] instr_word,
   input wire logic        dest_to_file,
   input wire logic        bank_select_en,
   input wire logic [7:0]  file_addr,
   input wire logic [7:0]  bit_mask,
   input wire logic [2:0]  bit_pos,
   input wire logic [1:0]  table_mode,
   input wire logic        fast_save,
   input wire logic        fast_restore,
   input wire logic [4:0]  alu_flags_in,
   input wire logic [4:0]  alu_flags_we,
   input wire logic [4:0]  status_flags
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence steady_run;
      exec_stb ##1 prog_rd [*4];
   endsequence
   stb_period_a: assert property (steady_run |-> exec_stb)
      else $error("instruction cycle is not four clocks");
   stb_gap_a: assert property (exec_stb |=> !exec_stb [*3])
      else $error("instruction strobe repeats too soon");
   write_resp_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   flag_mask_a: assert property (
      ((status_flags ^ $past(status_flags)) & ~$past(alu_flags_we)) == 5'h00)
      else $error("status flag changed without its enable");
   flag_data_a: assert property ($changed(status_flags) |->
      ((status_flags ^ $past(alu_flags_in)) & (status_flags ^ $past(status_flags))) == 5'h00)
      else $error("status flag took a wrong value");
   byte_fields_a: assert property (exec_stb && instr_word[15:12] == 4'h2 |->
      dest_to_file == instr_word[9] && bank_select_en == instr_word[8]
      && file_addr == instr_word[7:0]) else $error("byte operand fields wrong");
   bit_fields_a: assert property (exec_stb && instr_word[15:14] == 2'b10 |->
      bit_pos == instr_word[11:9] && bit_mask == (8'h01 << instr_word[11:9]))
      else $error("bit position fields wrong");
   table_mode_a: assert property (exec_stb && instr_word[15:2] == CID_OP_TBL |->
      table_mode == instr_word[1:0]) else $error("table mode wrong");
   fast_call_a: assert property (fast_save |->
      instr_word[15:9] == CID_OP_CALL && instr_word[8]) else $error("stray shadow save");
   fast_ret_a: assert property (fast_restore |-> instr_word[0] &&
      (instr_word[15:1] == CID_OP_RET || instr_word[15:1] == CID_OP_RETFIE))
      else $error("stray shadow restore");
endmodule : cid_monitor
bind cid_decoder cid_monitor cid_monitor_i (.*);
`default_nettype wire

/* verif/cid_prog_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module cid_prog_mem
   import cid_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic [CID_PC_W-1:0] prog_addr,
   input  wire logic                prog_rd,
   output logic      [15:0]         prog_data
);
   logic [15:0] mem [64];
   logic [15:0] last_word = 16'h0000;
   always_ff @(posedge aclk) begin
      if (prog_rd) begin
         last_word <= mem[prog_addr[6:1]];
      end
   end
   // One 16-bit word per even byte address; an idle port shows the complement.
   assign prog_data = prog_rd ? mem[prog_addr[6:1]] : ~last_word;
endmodule : cid_prog_mem
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import cid_pkg::*;
   // Second words carry 1111 on top.
   localparam logic [15:0] PROG [24] = '{16'h2655, 16'h8A33, 16'h0E7F, 16'h0008,
      16'h0009, 16'h000A, 16'h000B, 16'hEF10, 16'hF000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hC123, 16'hF456, 16'h6233, 16'hC001,
      16'hF002, 16'hED20, 16'hF000, 16'hD010};
   // All ones marks a slot whose word is not fixed, only its timing.
   localparam logic [15:0] EXP [23] = '{16'h2655, 16'h8A33, 16'h0E7F, 16'h0008,
      16'h0009, 16'h000A, 16'h000B, 16'hEF10, 16'hFFFF, 16'hC123, 16'hFFFF, 16'h6233,
      16'h0000, 16'hFFFF, 16'hED20, 16'hFFFF, 16'h0013, 16'h0000, 16'hD010, 16'h0000,
      16'hFFFF, 16'h0EA5, 16'h0000};
   logic        aclk, aresetn, cond_true, pc_written, prog_rd, exec_stb;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, bit_mask, file_addr, lit8;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, dest_to_file, bank_select_en;
   logic        fast_save, fast_restore;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, table_mode, rs, osc_phase, indirect_pointer_sel;
   logic [20:0] prog_addr, pc_load_value;
   logic [15:0] prog_data, instr_word, operand_word;
   logic [4:0]  alu_flags_in, alu_flags_we, status_flags;
   logic [11:0] move_src, move_dst, lit12;
   logic [19:0] lit20;
   logic [2:0]  bit_pos;
   int          mismatches, check_count, cyc, g;
   cid_decoder cid_decoder_i (.*);
   cid_prog_mem cid_prog_mem_i (.*);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic conclude();
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         conclude();
      end
   end
   // Skip test passes only for the compare-and-skip word.
   always @(posedge aclk) cond_true <= (instr_word === 16'h6233);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      rs = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (rs === 2'h3) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      rs = 2'h3;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (rs === 2'h3) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rs = s_axi_rresp;
            rd = s_axi_rdata;
            s_axi_rready <= 1'b0;
         end
      end
   endtask : axi_rd
   task automatic wait_stb(output int n);
      n = 0;
      do begin
         @(posedge aclk);
         #1;
         n++;
      end while (exec_stb !== 1'b1 && n < 20);
   endtask : wait_stb
   initial begin
      {aresetn, cond_true, pc_written, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      pc_load_value = 21'h00002E;
      alu_flags_in = 5'h15;
      alu_flags_we = 5'h1F;
      cyc = 0;
      for (int i = 0; i < 64; i++) cid_prog_mem_i.mem[i] = (i < 24) ? PROG[i] : 16'h0000;
      cid_prog_mem_i.mem[32] = 16'h0013;
      cid_prog_mem_i.mem[40] = 16'hF123;
      cid_prog_mem_i.mem[41] = 16'h0EA5;
      cid_prog_mem_i.mem[42] = 16'hE805;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(CID_REG_CTRL);
      check(rd, 32'h0000_0000);
      axi_rd(8'h18);
      check({rs, rd[29:0]}, {CID_RESP_ERR, 30'h0});
      axi_wr(CID_REG_PC, 32'h0000_0000);
      check(rs, CID_RESP_OK);
      axi_wr(CID_REG_CTRL, 32'h0000_0001);
      for (int k = 0; k < 23; k++) begin
         wait_stb(g);
         if (k == 0) begin
            for (int t = 0; t < 8 && instr_word !== EXP[0]; t++) wait_stb(g);
         end else begin
            check(g, 4);
            check(osc_phase, 2'h3);
         end
         if (EXP[k] !== 16'hFFFF) check(instr_word, EXP[k]);
         case (k)
            0: check({dest_to_file, bank_select_en, file_addr}, 10'h255);
            1: check({bit_pos, bit_mask}, 11'h520);
            2: check({lit8, lit12}, 20'h7FE7F);
            3, 4, 5, 6: check(table_mode, k - 3);
            8: check(lit20, 20'h00010);
            9: check(move_src, 12'h123);
            10: check({move_dst, operand_word}, 28'h456F456);
            14: check(fast_save, 1'b1);
            16: check(fast_restore, 1'b1);
            21: check({indirect_pointer_sel, lit8}, 10'h2A5);
            22: check(instr_word, CID_NOP_WORD);
            default: ;
         endcase
      end
      check(status_flags, 5'h15);
      @(posedge aclk);
      alu_flags_in <= 5'h0A;
      alu_flags_we <= 5'h03;
      pc_written <= 1'b1;
      wait_stb(g);
      check(instr_word, CID_NOP_WORD);
      @(posedge aclk);
      pc_written <= 1'b0;
      wait_stb(g);
      check(instr_word, PROG[23]);
      check(status_flags, 5'h16);
      axi_rd(CID_REG_FLAG);
      check(rd[4:0], 5'h16);
      axi_wr(CID_REG_CTRL, 32'h0000_0000);
      conclude();
   end
endmodule : tb
`default_nettype wire
